// *** core/reset_source_pkg.sv ***
package reset_source_pkg;

  // Register map (byte addresses; printed offset is a multiple of four)
  localparam logic [11:0] reset_status_addr = 12'hff0;
  localparam logic [11:0] control_addr = 12'hff4;
  localparam logic [11:0] irq_status_addr = 12'hff8;
  localparam logic [11:0] irq_mask_addr = 12'hffc;

  // Status field positions
  localparam int por_bit = 7;
  localparam int stop_bit = 6;
  localparam int wdt_bit = 5;
  localparam int pin_bit = 4;

  // Control field positions
  localparam int ctl_wdt_sel_bit = 0;
  localparam int ctl_stop_bit = 1;

  // Interrupt status field positions
  localparam int irq_wdt_bit = 0;
  localparam int irq_reset_bit = 1;

  // Reset values
  localparam logic [7:0] status_reset = 8'h80;
  localparam logic [7:0] watchdog_ctl_reset = 8'h00;
  localparam logic [1:0] control_reset = 2'h1;
  localparam logic [1:0] irq_reset = 2'h0;

  // Timing
  localparam int clk_mhz = 40;
  localparam int pin_min_cycles = 4;
  localparam int reset_hold_ns = 400;
  localparam int reset_hold_cycles = (reset_hold_ns * clk_mhz + 999) / 1000;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_hold = 3'b010,
    st_release = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic [11:0] awaddr;
    logic aw_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_full;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_state_t;

  typedef struct packed {
    logic [2:0] pin_sync;
    logic pin_low;
    logic [2:0] pin_count;
    seq_state_t seq;
    logic [4:0] hold_count;
    logic sys_reset_n;
    logic pin_drive_oe;
    logic [7:0] status;
    logic [7:0] watchdog_ctl;
    logic [1:0] control;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    bus_state_t bus;
  } ctrl_state_t;

endpackage : reset_source_pkg

// *** core/reset_source_controller.sv ***
// Behaviour
// - Pin, power-on, brown-out, watchdog (select bit 1) or stop exit (stop mode only) starts a reset
// - Reset pin is an input and is driven low while reset runs
// - Watchdog timeout resets in normal or stop mode when select bit is 1
// - Select bit 0 makes watchdog timeout an interrupt, no reset
// - Watchdog status is set whenever the watchdog caused the reset
// - Pin low for four clocks or more starts the reset sequence
// - In stop mode a filtered pin low resets; short glitches ignored
// - Status register is read-only; a read clears its upper four bits
// - Status reads and watchdog control writes share one address
// - Bit 7 set by power-on; cleared by watchdog, stop recovery or read
// - Bit 6 set by stop recovery; cleared by power-on, non-stop watchdog, read
// - Bits 6 and 5 both set mean watchdog caused the stop recovery
// - Bit 5 set by watchdog; cleared by power-on, pin-change recovery, read
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic power_on_detect,
  input wire logic brown_out_detect,
  input wire logic watchdog_timeout,
  input wire logic stop_exit,
  input wire logic pin_change_wake,
  output logic sys_reset_n,
  output logic [7:0] watchdog_ctl,
  output logic watchdog_ctl_write,
  output logic irq
);

  reset_source_pkg::ctrl_state_t cur;
  reset_source_pkg::ctrl_state_t nxt;
  logic write_strobe;
  logic wctl_pulse;
  logic pin_echo;
  logic next_pin_echo;

  always_comb begin
    logic pin_event;
    logic wdt_reset;
    logic wdt_irq;
    logic stop_wake;
    logic any_reset;
    logic read_status;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    pin_event = 1'b0;
    wdt_reset = 1'b0;
    wdt_irq = 1'b0;
    stop_wake = 1'b0;
    any_reset = 1'b0;
    read_status = 1'b0;
    irq_set = 2'h0;
    irq_clr = 2'h0;
    nxt = cur;
    write_strobe = 1'b0;

    // Pin is asynchronous: three stages, a change counts once stages two and three agree
    nxt.pin_sync = {cur.pin_sync[1:0], reset_pin_in};
    if (cur.pin_sync[2] == cur.pin_sync[1]) begin
      nxt.pin_low = ~cur.pin_sync[2];
    end
    // Our own drive is excluded, otherwise the pin would hold itself in reset
    if (cur.pin_low && !(cur.pin_drive_oe || pin_echo)) begin
      if (cur.pin_count != 3'(reset_source_pkg::pin_min_cycles)) begin
        nxt.pin_count = cur.pin_count + 3'h1;
      end
    end else begin
      nxt.pin_count = 3'h0;
    end
    // Count saturates so a long low fires once; glitches never reach it
    pin_event = cur.pin_low && !(cur.pin_drive_oe || pin_echo) &&
      (cur.pin_count == 3'(reset_source_pkg::pin_min_cycles - 1));

    wdt_reset = watchdog_timeout && cur.control[reset_source_pkg::ctl_wdt_sel_bit];
    wdt_irq = watchdog_timeout && !cur.control[reset_source_pkg::ctl_wdt_sel_bit];
    stop_wake = stop_exit && cur.control[reset_source_pkg::ctl_stop_bit];
    any_reset = pin_event || power_on_detect || brown_out_detect || wdt_reset || stop_wake;

    // Reset sequence
    case (cur.seq)
      reset_source_pkg::st_idle: begin
        if (any_reset) begin
          nxt.seq = reset_source_pkg::st_hold;
          nxt.hold_count = 5'h0;
          nxt.sys_reset_n = 1'b0;
          nxt.pin_drive_oe = 1'b1;
        end
      end
      reset_source_pkg::st_hold: begin
        if (cur.hold_count == 5'(reset_source_pkg::reset_hold_cycles - 1)) begin
          nxt.seq = reset_source_pkg::st_release;
          nxt.pin_drive_oe = 1'b0;
        end else begin
          nxt.hold_count = cur.hold_count + 5'h1;
        end
      end
      reset_source_pkg::st_release: begin
        nxt.seq = reset_source_pkg::st_idle;
        nxt.sys_reset_n = 1'b1;
      end
      default: begin
        nxt.seq = reset_source_pkg::st_idle;
      end
    endcase

    // Bus: write address and data in either order, response after both
    if (!cur.bus.aw_full && s_axi_awvalid) begin
      nxt.bus.awaddr = s_axi_awaddr;
      nxt.bus.aw_full = 1'b1;
    end
    if (!cur.bus.w_full && s_axi_wvalid) begin
      nxt.bus.wdata = s_axi_wdata;
      nxt.bus.wstrb = s_axi_wstrb;
      nxt.bus.w_full = 1'b1;
    end
    if (cur.bus.aw_full && cur.bus.w_full && !cur.bus.bvalid) begin
      write_strobe = 1'b1;
      nxt.bus.aw_full = 1'b0;
      nxt.bus.w_full = 1'b0;
      nxt.bus.bvalid = 1'b1;
      nxt.bus.bresp = reset_source_pkg::resp_okay;
      if (cur.bus.awaddr == reset_source_pkg::reset_status_addr) begin
        if (cur.bus.wstrb[0]) nxt.watchdog_ctl = cur.bus.wdata[7:0];
      end else if (cur.bus.awaddr == reset_source_pkg::control_addr) begin
        if (cur.bus.wstrb[0]) nxt.control = cur.bus.wdata[1:0];
      end else if (cur.bus.awaddr == reset_source_pkg::irq_status_addr) begin
        if (cur.bus.wstrb[0]) irq_clr = cur.bus.wdata[1:0];
      end else if (cur.bus.awaddr == reset_source_pkg::irq_mask_addr) begin
        if (cur.bus.wstrb[0]) nxt.irq_mask = cur.bus.wdata[1:0];
      end else begin
        nxt.bus.bresp = reset_source_pkg::resp_slverr;
      end
    end
    if (cur.bus.bvalid && s_axi_bready) begin
      nxt.bus.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !cur.bus.rvalid) begin
      nxt.bus.rvalid = 1'b1;
      nxt.bus.rresp = reset_source_pkg::resp_okay;
      nxt.bus.rdata = 32'h0;
      if (s_axi_araddr == reset_source_pkg::reset_status_addr) begin
        nxt.bus.rdata = {24'h0, cur.status[7:4], 4'h0};
        read_status = 1'b1;
      end else if (s_axi_araddr == reset_source_pkg::control_addr) begin
        nxt.bus.rdata = {30'h0, cur.control};
      end else if (s_axi_araddr == reset_source_pkg::irq_status_addr) begin
        nxt.bus.rdata = {30'h0, cur.irq_status};
      end else if (s_axi_araddr == reset_source_pkg::irq_mask_addr) begin
        nxt.bus.rdata = {30'h0, cur.irq_mask};
      end else begin
        nxt.bus.rresp = reset_source_pkg::resp_slverr;
      end
    end
    if (cur.bus.rvalid && s_axi_rready) begin
      nxt.bus.rvalid = 1'b0;
    end

    // Status: read clears first, so a same-cycle event still lands
    if (read_status) begin
      nxt.status[7:4] = 4'h0;
    end
    if (wdt_reset || stop_wake) begin
      nxt.status[reset_source_pkg::por_bit] = 1'b0;
    end
    if (power_on_detect || (wdt_reset && !cur.control[reset_source_pkg::ctl_stop_bit])) begin
      nxt.status[reset_source_pkg::stop_bit] = 1'b0;
    end
    if (power_on_detect || (stop_wake && pin_change_wake)) begin
      nxt.status[reset_source_pkg::wdt_bit] = 1'b0;
    end
    if (any_reset) begin
      nxt.status[reset_source_pkg::pin_bit] = pin_event;
    end
    if (stop_wake || (wdt_reset && cur.control[reset_source_pkg::ctl_stop_bit])) begin
      nxt.status[reset_source_pkg::stop_bit] = 1'b1;
    end
    if (watchdog_timeout) begin
      nxt.status[reset_source_pkg::wdt_bit] = 1'b1;
    end
    if (power_on_detect) begin
      nxt.status[reset_source_pkg::por_bit] = 1'b1;
    end
    nxt.status[3:0] = 4'h0;
    // Stop mode ends with any reset
    if (any_reset) begin
      nxt.control[reset_source_pkg::ctl_stop_bit] = 1'b0;
    end

    // Interrupts: set wins over write-one-to-clear
    irq_set[reset_source_pkg::irq_wdt_bit] = wdt_irq;
    irq_set[reset_source_pkg::irq_reset_bit] = any_reset;
    nxt.irq_status = (cur.irq_status & ~irq_clr) | irq_set;
    nxt.irq = |(nxt.irq_status & nxt.irq_mask);
  end

  assign wctl_pulse = write_strobe && cur.bus.wstrb[0] &&
    (cur.bus.awaddr == reset_source_pkg::reset_status_addr);

  logic wctl_write_q;

  // Synchroniser still shows our own drive after release; blank until it reads high
  assign next_pin_echo = cur.pin_drive_oe || (pin_echo && (cur.pin_sync != 3'h7));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      cur.pin_sync <= 3'h7;
      cur.seq <= reset_source_pkg::st_idle;
      cur.sys_reset_n <= 1'b1;
      cur.status <= reset_source_pkg::status_reset;
      cur.watchdog_ctl <= reset_source_pkg::watchdog_ctl_reset;
      cur.control <= reset_source_pkg::control_reset;
      cur.irq_status <= reset_source_pkg::irq_reset;
      cur.irq_mask <= reset_source_pkg::irq_reset;
      wctl_write_q <= 1'b0;
      pin_echo <= 1'b0;
    end else begin
      cur <= nxt;
      wctl_write_q <= wctl_pulse;
      pin_echo <= next_pin_echo;
    end
  end

  always_comb begin
    s_axi_awready = !cur.bus.aw_full;
    s_axi_wready = !cur.bus.w_full;
    s_axi_arready = !cur.bus.rvalid;
  end

  // Ready lines are decodes of flops; reset_pin_out is tied low; all other outputs are flops directly
  assign s_axi_bvalid = cur.bus.bvalid;
  assign s_axi_bresp = cur.bus.bresp;
  assign s_axi_rvalid = cur.bus.rvalid;
  assign s_axi_rdata = cur.bus.rdata;
  assign s_axi_rresp = cur.bus.rresp;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = cur.pin_drive_oe;
  assign sys_reset_n = cur.sys_reset_n;
  assign watchdog_ctl = cur.watchdog_ctl;
  assign watchdog_ctl_write = wctl_write_q;
  assign irq = cur.irq;

endmodule : reset_source_controller
`default_nettype wire

// *** tb/reset_source_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module reset_source_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic power_on_detect,
  input wire logic brown_out_detect,
  input wire logic watchdog_timeout,
  input wire logic stop_exit,
  input wire logic sys_reset_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Idle comes with the first high cycle; the release cycle still holds sys_reset_n low
  property p_src;
    $past(sys_reset_n) && sys_reset_n && (power_on_detect || brown_out_detect) |=> !sys_reset_n;
  endproperty
  a_src: assert property (p_src) else $error("source gave no reset");
  property p_oe_on; $fell(sys_reset_n) |-> reset_pin_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not driven");
  property p_oe_len;
    $rose(reset_pin_oe) |-> reset_pin_oe [*8] ##1 reset_pin_oe [*8] ##1 !reset_pin_oe;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("pin drive length");
  property p_rel; $fell(reset_pin_oe) |-> !sys_reset_n ##1 sys_reset_n; endproperty
  a_rel: assert property (p_rel) else $error("release order");
  property p_od; reset_pin_oe |-> !reset_pin_out; endproperty
  a_od: assert property (p_od) else $error("pin not pulled low");
  property p_pin; (sys_reset_n && !reset_pin_in) [*4] |-> ##[1:6] !sys_reset_n; endproperty
  a_pin: assert property (p_pin) else $error("pin low gave no reset");
  property p_quiet;
    (sys_reset_n && reset_pin_in && !power_on_detect && !brown_out_detect && !watchdog_timeout && !stop_exit) [*8]
      |=> sys_reset_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset with no source");
  property p_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == reset_source_pkg::reset_status_addr
      |=> s_axi_rvalid && s_axi_rresp == reset_source_pkg::resp_okay && s_axi_rdata[3:0] == 4'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("status read");
endmodule : reset_source_properties
bind reset_source_controller reset_source_properties i_props (.*);
`default_nettype wire

// *** tb/reset_pin_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module reset_pin_partner (
  input wire logic aclk,
  input wire logic pull,
  input wire logic [3:0] plen,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic wdt_req,
  output logic reset_pin_in,
  output logic watchdog_timeout
);
  logic [3:0] cnt = 4'h0;
  // Holds the pin for the commanded count; short counts are glitches
  always_ff @(posedge aclk) begin
    cnt <= pull ? plen : ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0);
  end
  // Pull-up wire, low while either side pulls
  assign reset_pin_in = !((cnt != 4'h0) || (reset_pin_oe && !reset_pin_out));
  assign watchdog_timeout = wdt_req;
endmodule : reset_pin_partner
`default_nettype wire

// *** tb/reset_source_controller_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
module reset_source_controller_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, plen = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic power_on_detect = 1'b0, brown_out_detect = 1'b0, stop_exit = 1'b0, pin_change_wake = 1'b0;
  logic wdt_req = 1'b0, pull = 1'b0, saw_rst = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reset_pin_in, reset_pin_out;
  logic reset_pin_oe, watchdog_timeout, sys_reset_n, watchdog_ctl_write, irq;
  logic [7:0] watchdog_ctl, got;
  logic [1:0] ctl [5] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h1};
  int src [5] = '{2, 1, 3, 2, 4};
  int fail_count = 0;
  int comparisons = 0;
  int wctl_count = 0;
  reset_source_controller i_dut (.*);
  reset_pin_partner i_pin (.aclk, .pull, .plen, .reset_pin_out, .reset_pin_oe, .wdt_req, .reset_pin_in,
    .watchdog_timeout);
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (!sys_reset_n) saw_rst <= 1'b1;
  always @(posedge aclk) if (watchdog_ctl_write === 1'b1) wctl_count <= wctl_count + 1;
  task automatic stop_test();
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    got = s_axi_rdata[7:0];
    s_axi_rready <= 1'b0;
  endtask : rd
  // Sources: 0 power-on, 1 brown-out, 2 watchdog, 3 stop exit, 4 pin
  task automatic fire(input int s, input logic [3:0] n);
    @(posedge aclk);
    saw_rst <= 1'b0;
    plen <= n;
    {power_on_detect, brown_out_detect, wdt_req, stop_exit, pull} <= 5'h10 >> s;
    @(posedge aclk);
    {power_on_detect, brown_out_detect, wdt_req, stop_exit, pull} <= 5'h00;
    repeat (40) @(posedge aclk);
  endtask : fire
  function automatic logic [7:0] exp_stat(input int s, input logic stop);
    logic [7:0] e;
    e = 8'h00;
    e[reset_source_pkg::por_bit] = (s == 0);
    e[reset_source_pkg::stop_bit] = stop;
    e[reset_source_pkg::wdt_bit] = (s == 2);
    e[reset_source_pkg::pin_bit] = (s == 4);
    return e;
  endfunction : exp_stat
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hfebe));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    pin_change_wake <= 1'b1;
    rd(reset_source_pkg::reset_status_addr);
    `CHK(got, reset_source_pkg::status_reset)
    rd(reset_source_pkg::reset_status_addr);
    `CHK(got, 8'h00)
    d = $urandom;
    wr(reset_source_pkg::reset_status_addr, d);
    repeat (2) @(posedge aclk);
    `CHK(watchdog_ctl, d[7:0])
    `CHK(wctl_count, 1)
    rd(reset_source_pkg::reset_status_addr);
    `CHK(got, 8'h00)
    wr(12'h100, d);
    `CHK(resp, reset_source_pkg::resp_slverr)
    fire(4, 4'($urandom_range(3, 1)));
    `CHK(saw_rst, 1'b0)
    // Power-on left unread, so the watchdog entry must clear bit 7
    fire(0, 4'h0);
    for (int i = 0; i < 5; i++) begin
      wr(reset_source_pkg::control_addr, {30'h0, ctl[i]});
      fire(src[i], 4'h4);
      `CHK(saw_rst, 1'b1)
      rd(reset_source_pkg::reset_status_addr);
      `CHK(got, exp_stat(src[i], ctl[i][1]))
    end
    wr(reset_source_pkg::control_addr, 32'h0);
    wr(reset_source_pkg::irq_mask_addr, 32'h0);
    fire(2, 4'h0);
    `CHK(saw_rst, 1'b0)
    `CHK(irq, 1'b0)
    wr(reset_source_pkg::irq_mask_addr, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    rd(reset_source_pkg::reset_status_addr);
    `CHK(got, exp_stat(2, 1'b0))
    wr(reset_source_pkg::irq_status_addr, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    stop_test();
  end
endmodule : reset_source_controller_tb
`default_nettype wire
